// ==== sim/bdec_devsys.sv ====
// development system model: drives the breakpoint request pin
// assumes core_clk and a synchronous active-high reset from the bench
`timescale 1ns/1ps
module bdec_devsys (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// bench control
	input  wire logic want_en,
	input  wire logic brk,
	// pin, pulled up when released
	output logic      breakpoint_request_n
);
	int hold;
	initial begin
		breakpoint_request_n = 1'b1;
		hold = 0;
	end
	always @(posedge core_clk) begin
		if (rst) begin
			breakpoint_request_n <= ~want_en;
			hold <= 2;
		end else if (hold != 0) begin
			hold <= hold - 1;
		end else begin
			breakpoint_request_n <= ~brk;
		end
	end
endmodule

// ==== sim/tb_top.sv ====
// testbench for the background debug entry control block
// assumes bdec_top, bdec_pkg and the development system model
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 0, rst = 1, clk_en = 1, want_en = 1, brk = 0;
	logic breakpoint_request_n_ack = 0, breakpoint_request_n_on_prefetch = 0, prefetch_flushed = 0, periph_breakpoint_request_n = 0;
	logic opcode_valid = 0, double_fault = 0, trace_enable = 0, instr_done = 0;
	logic resume_cmd = 0;
	logic [15:0] opcode = 16'h0000, fault_ssw = 16'h0000;
	bdec_pkg::bdec_pipe_t pipe_evt = '0;
	wire logic breakpoint_request_n;
	logic background_debug_mode, debug_enabled, debug_halt, serial_enable;
	logic exec_suspend, fetch_enable, cpu_halted, fetch_track_out, pipe_track_out;
	bdec_pkg::bdec_exc_t exc_out;
	logic [31:0] temp_scratch_reg;
	int fails = 0, samples_checked = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	bdec_devsys devsys (.core_clk, .rst, .want_en, .brk, .breakpoint_request_n);
	bdec_top uut (.core_clk, .rst, .clk_en, .breakpoint_request_n, .breakpoint_request_n_ack,
		.breakpoint_request_n_on_prefetch, .prefetch_flushed, .periph_breakpoint_request_n, .opcode_valid, .opcode,
		.double_fault, .fault_ssw, .trace_enable, .instr_done, .resume_cmd, .pipe_evt,
		.background_debug_mode, .debug_enabled, .debug_halt, .serial_enable, .exec_suspend,
		.fetch_enable, .cpu_halted, .exc_out, .temp_scratch_reg, .fetch_track_out,
		.pipe_track_out);
	task automatic end_sim();
		if (fails == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic do_reset(input logic e);
		want_en = e;
		rst = 1;
		repeat (3) @(negedge core_clk);
		rst = 0;
		repeat (5) @(negedge core_clk);
		chk(debug_enabled, e);
	endtask
	// one source event, taken at the next rising edge
	task automatic ev(input int k, input logic [15:0] op);
		@(negedge core_clk);
		case (k)
			0: breakpoint_request_n_ack = 1;
			1: periph_breakpoint_request_n = 1;
			2: begin
				opcode_valid = 1;
				opcode = op;
			end
			3: begin
				double_fault = 1;
				fault_ssw = 16'h5A3C;
			end
			4: begin
				trace_enable = 1;
				instr_done = 1;
			end
			default: begin
				breakpoint_request_n_ack = 1;
				breakpoint_request_n_on_prefetch = 1;
				prefetch_flushed = 1;
			end
		endcase
		@(posedge core_clk);
		@(negedge core_clk);
		{breakpoint_request_n_ack, periph_breakpoint_request_n, opcode_valid, double_fault, instr_done} = '0;
		{breakpoint_request_n_on_prefetch, prefetch_flushed, trace_enable} = '0;
	endtask
	task automatic t_enabled();
		int kinds [4];
		logic [31:0] cause [4];
		kinds = '{2, 0, 3, 1};
		cause = '{32'h0000_0001, 32'h0000_0000, 32'h5A3C_FFFF, 32'h0000_0000};
		do_reset(1);
		for (int k = 0; k < 4; k++) begin
			ev(kinds[k], bdec_pkg::BACKGROUND_ENTRY_OPCODE_OPCODE);
			chk({background_debug_mode, debug_halt, exec_suspend, fetch_enable}, 4'hE);
			chk(temp_scratch_reg, cause[k]);
			chk({serial_enable, exc_out.valid}, 2'b00);
			@(negedge core_clk);
			chk(serial_enable, 1);
			brk = 1;
			resume_cmd = 1;
			@(posedge core_clk);
			@(negedge core_clk);
			resume_cmd = 0;
			brk = 0;
			chk({background_debug_mode, fetch_enable}, 2'b01);
			repeat (3) @(negedge core_clk);
			chk(debug_enabled, 1);
		end
		chk(cpu_halted, 0);
		ev(5, 16'h0000);
		chk(background_debug_mode, 0);
		ev(2, bdec_pkg::SWBKPT_LO);
		chk(background_debug_mode, 0);
		chk(exc_out, {1'b1, bdec_pkg::VEC_ILLEGAL});
	endtask
	task automatic t_disabled();
		logic [15:0] ops [3];
		ops = '{bdec_pkg::BACKGROUND_ENTRY_OPCODE_OPCODE, bdec_pkg::SWBKPT_LO, bdec_pkg::SWBKPT_HI};
		do_reset(0);
		brk = 1;
		repeat (4) @(negedge core_clk);
		brk = 0;
		chk(debug_enabled, 0);
		ev(0, 16'h0000);
		chk(exc_out, {1'b1, bdec_pkg::VEC_BREAKPOINT_REQUEST_N});
		chk(background_debug_mode, 0);
		for (int i = 0; i < 3; i++) begin
			ev(2, ops[i]);
			chk(exc_out, {1'b1, bdec_pkg::VEC_ILLEGAL});
			chk(background_debug_mode, 0);
		end
		ev(4, 16'h0000);
		chk(exc_out, {1'b1, bdec_pkg::VEC_TRACE});
		ev(3, 16'h0000);
		chk({cpu_halted, background_debug_mode}, 2'b10);
	endtask
	task automatic t_tracking();
		do_reset(1);
		chk({fetch_track_out, pipe_track_out}, 2'b11);
		for (int i = 0; i < 4; i++) begin
			pipe_evt = bdec_pkg::bdec_pipe_t'(4'b1000 >> i);
			@(posedge core_clk);
			@(negedge core_clk);
			pipe_evt = '0;
			chk({fetch_track_out, pipe_track_out}, (i < 2) ? 2'b01 : 2'b10);
			@(negedge core_clk);
			chk({fetch_track_out, pipe_track_out}, 2'b11);
		end
		clk_en = 0;
		pipe_evt = bdec_pkg::bdec_pipe_t'(4'b1111);
		breakpoint_request_n_ack = 1;
		repeat (2) @(negedge core_clk);
		chk({fetch_track_out, pipe_track_out, background_debug_mode}, 3'b110);
		pipe_evt = '0;
		breakpoint_request_n_ack = 0;
		clk_en = 1;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		t_enabled();
		t_tracking();
		t_disabled();
		end_sim();
	end
endmodule

// ==== src/bdec_pkg.sv ====
// package for the background debug entry control block
// assumes one core clock domain and synchronous active-high reset
package bdec_pkg;

	localparam logic [15:0] BACKGROUND_ENTRY_OPCODE_OPCODE      = 16'h4AFA;
	localparam logic [15:0] SWBKPT_LO        = 16'h4848;
	localparam logic [15:0] SWBKPT_HI        = 16'h484F;
	localparam logic [7:0]  VEC_BREAKPOINT_REQUEST_N         = 8'h0C;
	localparam logic [7:0]  VEC_ILLEGAL      = 8'h04;
	localparam logic [7:0]  VEC_TRACE        = 8'h09;
	localparam logic [15:0] CAUSE_DBL_FAULT  = 16'hFFFF;
	localparam logic [15:0] CAUSE_OPCODE     = 16'h0001;
	localparam logic [15:0] CAUSE_HW_BREAKPOINT_REQUEST_N    = 16'h0000;
	localparam logic [15:0] SSW_NONE         = 16'h0000;
	localparam int          SYNC_STAGES      = 2;
	localparam int          BREAKPOINT_REQUEST_N_HOLD_CYCLES = 2;

	typedef enum logic [1:0] {
		BDEC_SRC_NONE,
		BDEC_SRC_HW,
		BDEC_SRC_OP,
		BDEC_SRC_DBF
	} bdec_src_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  vector;
	} bdec_exc_t;

	typedef struct packed {
		logic        fetch_load;
		logic        flush;
		logic        advance;
		logic        exec_start;
	} bdec_pipe_t;

endpackage

// ==== src/bdec_sync.sv ====
// two-stage synchroniser for the breakpoint request pin
// assumes the pin is already in the core clock domain per house rule
`timescale 1ns/1ps
module bdec_sync (
	// clock and control
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// data
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_reg;

	// keeps shifting during reset so the pin level reaches the release edge
	always_ff @(posedge core_clk) begin
		if (rst || clk_en) begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule

// ==== src/bdec_top.sv ====
// background debug entry control: enable latch, source routing, tracking
// assumes core pipeline supplies decode, fault and fetch event strobes
`timescale 1ns/1ps
module bdec_top (
	// clock and control
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                clk_en,
	// development system pin
	input  wire logic                breakpoint_request_n,
	// core events
	input  wire logic                breakpoint_request_n_ack,
	input  wire logic                breakpoint_request_n_on_prefetch,
	input  wire logic                prefetch_flushed,
	input  wire logic                periph_breakpoint_request_n,
	input  wire logic                opcode_valid,
	input  wire logic [15:0]         opcode,
	input  wire logic                double_fault,
	input  wire logic [15:0]         fault_ssw,
	input  wire logic                trace_enable,
	input  wire logic                instr_done,
	input  wire logic                resume_cmd,
	input  wire bdec_pkg::bdec_pipe_t pipe_evt,
	// results
	output logic                     background_debug_mode,
	output logic                     debug_enabled,
	output logic                     debug_halt,
	output logic                     serial_enable,
	output logic                     exec_suspend,
	output logic                     fetch_enable,
	output logic                     cpu_halted,
	output bdec_pkg::bdec_exc_t      exc_out,
	output logic [31:0]              temp_scratch_reg,
	output logic                     fetch_track_out,
	output logic                     pipe_track_out
);
	typedef enum logic [1:0] {
		BDEC_RUN,
		BDEC_FREEZE,
		BDEC_WAIT_CMD
	} bdec_state_t;

	function automatic logic is_sw_breakpoint_request_n(input logic [15:0] op);
		is_sw_breakpoint_request_n = (op >= bdec_pkg::SWBKPT_LO) && (op <= bdec_pkg::SWBKPT_HI);
	endfunction

	logic                breakpoint_request_n_sync;
	logic                rst_d_reg;
	bdec_state_t         state_reg;
	bdec_pkg::bdec_src_t src_next;
	logic [15:0]         ssw_next;
	logic                hw_breakpoint_request_n;
	logic                op_background_entry_opcode;
	logic                op_swbk;
	logic                running;

	bdec_sync u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.d_in     (breakpoint_request_n),
		.q_out    (breakpoint_request_n_sync)
	);

	assign running = (state_reg == BDEC_RUN);
	// flushed prefetch breakpoints dropped, operand ones kept
	assign hw_breakpoint_request_n = running && ((breakpoint_request_n_ack && !(breakpoint_request_n_on_prefetch && prefetch_flushed))
		|| periph_breakpoint_request_n);
	assign op_background_entry_opcode = running && opcode_valid && (opcode == bdec_pkg::BACKGROUND_ENTRY_OPCODE_OPCODE);
	assign op_swbk = running && opcode_valid && is_sw_breakpoint_request_n(opcode);

	// reset edge tracking
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			rst_d_reg <= rst;
		end
	end

	// enable latched at first edge after release, held until next reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			debug_enabled <= 1'b0;
		end else if (clk_en && rst_d_reg) begin
			debug_enabled <= !breakpoint_request_n_sync;
		end
	end

	// entry source priority
	always_comb begin
		src_next = bdec_pkg::BDEC_SRC_NONE;
		ssw_next = bdec_pkg::SSW_NONE;
		if (running && debug_enabled) begin
			if (double_fault) begin
				src_next = bdec_pkg::BDEC_SRC_DBF;
				ssw_next = fault_ssw;
			end else if (op_background_entry_opcode) begin
				src_next = bdec_pkg::BDEC_SRC_OP;
			end else if (hw_breakpoint_request_n) begin
				src_next = bdec_pkg::BDEC_SRC_HW;
			end
		end
	end

	// background mode sequencer; no acknowledge cycle is ever run
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= BDEC_RUN;
		end else if (clk_en) begin
			case (state_reg)
				BDEC_RUN: begin
					if (src_next != bdec_pkg::BDEC_SRC_NONE) begin
						state_reg <= BDEC_FREEZE;
					end
				end
				BDEC_FREEZE: begin
					state_reg <= BDEC_WAIT_CMD;
				end
				BDEC_WAIT_CMD: begin
					if (resume_cmd) begin
						state_reg <= BDEC_RUN;
					end
				end
				default: begin
					state_reg <= BDEC_RUN;
				end
			endcase
		end
	end

	// mode outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			background_debug_mode <= 1'b0;
			debug_halt            <= 1'b0;
			serial_enable         <= 1'b0;
			exec_suspend          <= 1'b0;
			fetch_enable          <= 1'b0;
		end else if (clk_en) begin
			case (state_reg)
				BDEC_RUN: begin
					background_debug_mode <= src_next != bdec_pkg::BDEC_SRC_NONE;
					debug_halt            <= src_next != bdec_pkg::BDEC_SRC_NONE;
					exec_suspend          <= src_next != bdec_pkg::BDEC_SRC_NONE;
					fetch_enable          <= src_next == bdec_pkg::BDEC_SRC_NONE;
					serial_enable         <= 1'b0;
				end
				BDEC_FREEZE: begin
					serial_enable <= 1'b1;
				end
				BDEC_WAIT_CMD: begin
					if (resume_cmd) begin
						background_debug_mode <= 1'b0;
						debug_halt            <= 1'b0;
						exec_suspend          <= 1'b0;
						serial_enable         <= 1'b0;
						fetch_enable          <= 1'b1;
					end
				end
				default: begin
					background_debug_mode <= 1'b0;
					debug_halt            <= 1'b0;
					serial_enable         <= 1'b0;
					exec_suspend          <= 1'b0;
					fetch_enable          <= 1'b0;
				end
			endcase
		end
	end

	// entry cause record
	always_ff @(posedge core_clk) begin
		if (rst) begin
			temp_scratch_reg <= 32'h0000_0000;
		end else if (clk_en && running) begin
			case (src_next)
				bdec_pkg::BDEC_SRC_DBF: temp_scratch_reg <= {ssw_next,
					bdec_pkg::CAUSE_DBL_FAULT};
				bdec_pkg::BDEC_SRC_OP: temp_scratch_reg <= {16'h0000,
					bdec_pkg::CAUSE_OPCODE};
				bdec_pkg::BDEC_SRC_HW: temp_scratch_reg <= {16'h0000,
					bdec_pkg::CAUSE_HW_BREAKPOINT_REQUEST_N};
				default: temp_scratch_reg <= temp_scratch_reg;
			endcase
		end
	end

	// ordinary exceptions and halt
	always_ff @(posedge core_clk) begin
		if (rst) begin
			exc_out    <= '0;
			cpu_halted <= 1'b0;
		end else if (clk_en) begin
			exc_out <= '0;
			if (running && !debug_enabled && double_fault) begin
				cpu_halted <= 1'b1;
			end else if (running && !debug_enabled && op_background_entry_opcode) begin
				exc_out <= '{valid: 1'b1, vector: bdec_pkg::VEC_ILLEGAL};
			end else if (op_swbk) begin
				exc_out <= '{valid: 1'b1, vector: bdec_pkg::VEC_ILLEGAL};
			end else if (running && !debug_enabled && hw_breakpoint_request_n) begin
				exc_out <= '{valid: 1'b1, vector: bdec_pkg::VEC_BREAKPOINT_REQUEST_N};
			end else if (running && trace_enable && instr_done) begin
				exc_out <= '{valid: 1'b1, vector: bdec_pkg::VEC_TRACE};
			end
		end
	end

	// tracking outputs; idle high, pulse low on events
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fetch_track_out <= 1'b1;
			pipe_track_out  <= 1'b1;
		end else if (clk_en) begin
			fetch_track_out <= !(running && (pipe_evt.fetch_load || pipe_evt.flush));
			pipe_track_out  <= !(running && (pipe_evt.advance || pipe_evt.exec_start));
		end
	end

	// checks
	a_enable_latch: assert property (@(posedge core_clk) disable iff (rst)
		clk_en && $past(rst) && !rst |=> debug_enabled == !$past(breakpoint_request_n_sync))
		else $error("enable not latched from pin");
	a_enable_hold: assert property (@(posedge core_clk) disable iff (rst)
		!$past(rst) && !$past(rst_d_reg) |-> $stable(debug_enabled))
		else $error("enable changed outside reset");
	a_disabled_none: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && !debug_enabled |=> !background_debug_mode)
		else $error("entry while disabled");
	a_swbk_noentry: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		op_swbk && !double_fault && !hw_breakpoint_request_n |=> !background_debug_mode)
		else $error("software breakpoint entered background");
	a_entry_seq: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && src_next != bdec_pkg::BDEC_SRC_NONE
		|=> debug_halt && !serial_enable ##1 serial_enable)
		else $error("halt then serial order broken");
	a_vec_breakpoint_request_n: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && !debug_enabled && hw_breakpoint_request_n && !double_fault && !op_background_entry_opcode && !op_swbk
		|=> exc_out.valid && exc_out.vector == bdec_pkg::VEC_BREAKPOINT_REQUEST_N)
		else $error("breakpoint vector wrong");
	a_cause_dbf: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && src_next == bdec_pkg::BDEC_SRC_DBF
		|=> temp_scratch_reg[15:0] == bdec_pkg::CAUSE_DBL_FAULT)
		else $error("double fault cause wrong");
	a_cause_op: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && src_next == bdec_pkg::BDEC_SRC_OP
		|=> temp_scratch_reg == 32'h0000_0001)
		else $error("opcode cause wrong");
	a_no_fetch: assert property (@(posedge core_clk) disable iff (rst)
		serial_enable |-> !fetch_enable && exec_suspend)
		else $error("fetching during background");
	a_dbf_halt: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
		running && !debug_enabled && double_fault |=> cpu_halted)
		else $error("double fault did not halt");
endmodule
